// ---- rtl/sfs_consts.vh ----
/*
 * constants for the serial flash pin front end: opcodes, widths, phase counts.
 * assumes inclusion by the front end, its shift register module and the bench.
 */
`ifndef SFS_CONSTS_VH
`define SFS_CONSTS_VH

// ===========================================================================
// opcode values seen on the serial input
`define SFS_OP_DUAL_READ    8'h3b
`define SFS_OP_DUAL_PROG    8'ha2
`define SFS_OP_READ         8'h03

// ===========================================================================
// phase lengths in bits
`define SFS_CMD_BITS        4'h8
`define SFS_ADDR_BITS       5'h18
`define SFS_DUMMY_BITS      4'h8
`define SFS_BYTE_BITS       4'h8

// ===========================================================================
// reset values
`define SFS_BYTE_ZERO       8'h00
`define SFS_ADDR_ZERO       24'h000000

`endif

// ---- rtl/sfs_shift_out.v ----
/*
 * output shift register for read data, single or dual lane.
 * assumes advance strobes come from the front end on falling serial clock edges.
 */
`timescale 1ns/100ps
`include "sfs_consts.vh"

module sfs_shift_out
(
   input  wire       clk_sys,
   input  wire       rst_n,
   input  wire       load,
   input  wire [7:0] loadByte,
   input  wire       advance,
   input  wire       dualMode,
   output wire       bitHi,
   output wire       bitLo
);

   reg [7:0] shiftReg_ff;
   reg [7:0] nxt_shiftReg;

   // ========================================================================
   // shift msb first, two bits per step in dual mode
   always @*
   begin
      nxt_shiftReg = shiftReg_ff;
      if (load)
         nxt_shiftReg = loadByte;
      else if (advance && dualMode)
         nxt_shiftReg = {shiftReg_ff[5:0], 2'h0};
      else if (advance)
         nxt_shiftReg = {shiftReg_ff[6:0], 1'h0};
   end

   always @(posedge clk_sys)
   begin
      if (!rst_n)
         shiftReg_ff <= `SFS_BYTE_ZERO;
      else
         shiftReg_ff <= nxt_shiftReg;
   end

   assign bitHi = shiftReg_ff[7];
   assign bitLo = shiftReg_ff[6];

endmodule // sfs_shift_out

// ---- rtl/sfs_spi_front_end.v ----
/*
 * pin level serial front end of a serial flash: framing, sampling, dual modes,
 * hold and write protect. serial pins are sampled as synchronous inputs of
 * clk_sys, which must run well above the serial clock. array and self-timed
 * engine sit outside; they supply read bytes and the busy flag.
 */
`timescale 1ns/100ps
`include "sfs_consts.vh"

module sfs_spi_front_end
(
   input  wire        clk_sys,
   input  wire        rst_n,
   input  wire        selectN,
   input  wire        serialClk,
   input  wire        serialIn,
   output wire        serialInOut,
   output wire        serialInOe,
   input  wire        dual_in_data1,
   output wire        serialOut,
   output wire        serialOutOe,
   input  wire        writeProtectN,
   input  wire        holdN,
   input  wire        engineBusy,
   input  wire [7:0]  readByte,
   output wire        readByteReq,
   output reg  [7:0]  opcode_ff,
   output reg         opcodeValid_ff,
   output reg  [23:0] address_ff,
   output reg         addressValid_ff,
   output reg  [7:0]  writeByte_ff,
   output reg         writeByteValid_ff,
   output reg         opEnd_ff,
   output reg         hwLocked_ff,
   output wire        standby
);

   localparam [4:0] ST_IDLE  = 5'h01;
   localparam [4:0] ST_CMD   = 5'h02;
   localparam [4:0] ST_ADDR  = 5'h04;
   localparam [4:0] ST_DUMMY = 5'h08;
   localparam [4:0] ST_DATA  = 5'h10;

   reg  [4:0] state_ff;
   reg  [4:0] nxt_state;
   reg        sclkPrev_ff;
   reg        holdActive_ff;
   reg        nxt_holdActive;
   reg  [4:0] bitCnt_ff;
   reg  [4:0] nxt_bitCnt;
   reg  [7:0] inShift_ff;
   reg  [7:0] nxt_inShift;
   reg  [23:0] nxt_address;
   reg  [7:0] nxt_opcode;
   reg        nxt_opcodeValid;
   reg        nxt_addressValid;
   reg  [7:0] nxt_writeByte;
   reg        nxt_writeByteValid;
   reg        outEn_ff;
   reg        nxt_outEn;
   reg        pendStandby_ff;
   reg        nxt_pendStandby;
   reg        loadOut;
   reg        advOut;
   reg        outFirst_ff;
   reg        nxt_outFirst;

   wire       selected;
   wire       riseRaw;
   wire       fallRaw;
   wire       riseEdge;
   wire       fallEdge;
   wire       isDualRead;
   wire       isDualProg;
   wire       isRead;
   wire       bitHi;
   wire       bitLo;
   wire       byteDone;

   assign selected = ~selectN;
   assign riseRaw  = serialClk & ~sclkPrev_ff;
   assign fallRaw  = ~serialClk & sclkPrev_ff;
   assign riseEdge = riseRaw & selected & ~holdActive_ff;
   assign fallEdge = fallRaw & selected & ~holdActive_ff;
   assign isDualRead = opcode_ff == `SFS_OP_DUAL_READ;
   assign isDualProg = opcode_ff == `SFS_OP_DUAL_PROG;
   assign isRead     = opcode_ff == `SFS_OP_READ;

   // ========================================================================
   // hold tracking
   always @*
   begin
      nxt_holdActive = holdActive_ff;
      // hold starts only selected, clock low
      if (!holdN && selected && !serialClk)
         nxt_holdActive = 1'b1;
      else if (holdN || !selected)
         nxt_holdActive = 1'b0;
   end

   // ========================================================================
   // command, address, data sequencer
   assign byteDone = (bitCnt_ff + (isDualProg ? 5'h2 : 5'h1)) >= {1'b0, `SFS_BYTE_BITS};

   always @*
   begin
      nxt_state          = state_ff;
      nxt_bitCnt         = bitCnt_ff;
      nxt_inShift        = inShift_ff;
      nxt_address        = address_ff;
      nxt_opcode         = opcode_ff;
      nxt_opcodeValid    = 1'b0;
      nxt_addressValid   = 1'b0;
      nxt_writeByte      = writeByte_ff;
      nxt_writeByteValid = 1'b0;
      nxt_outEn          = outEn_ff;
      nxt_outFirst       = outFirst_ff;
      loadOut            = 1'b0;
      advOut             = 1'b0;
      if (!selected)
      begin
         nxt_state  = ST_IDLE;
         nxt_outEn  = 1'b0;
         nxt_bitCnt = 5'h00;
      end
      else
      begin
         case (state_ff)
            ST_IDLE:
            begin
               nxt_state  = ST_CMD;
               nxt_bitCnt = 5'h00;
               nxt_outEn  = 1'b0;
            end
            ST_CMD:
               if (riseEdge)
               begin
                  nxt_inShift = {inShift_ff[6:0], serialIn};
                  nxt_bitCnt  = bitCnt_ff + 5'h1;
                  if (bitCnt_ff == {1'b0, `SFS_CMD_BITS} - 5'h1)
                  begin
                     nxt_opcode      = {inShift_ff[6:0], serialIn};
                     nxt_opcodeValid = 1'b1;
                     nxt_state       = ST_ADDR;
                     nxt_bitCnt      = 5'h00;
                  end
               end
            ST_ADDR:
               if (riseEdge)
               begin
                  nxt_address = {address_ff[22:0], serialIn};
                  nxt_bitCnt  = bitCnt_ff + 5'h1;
                  if (bitCnt_ff == `SFS_ADDR_BITS - 5'h1)
                  begin
                     nxt_addressValid = 1'b1;
                     nxt_bitCnt       = 5'h00;
                     nxt_state        = isRead ? ST_DATA : ST_DUMMY;
                     nxt_outFirst     = 1'b1;
                  end
               end
            ST_DUMMY:
               if (riseEdge)
               begin
                  nxt_bitCnt = bitCnt_ff + 5'h1;
                  if (bitCnt_ff == {1'b0, `SFS_DUMMY_BITS} - 5'h1 || isDualProg)
                  begin
                     nxt_bitCnt = 5'h00;
                     nxt_state  = ST_DATA;
                  end
                  // dual program data starts at once
                  if (isDualProg)
                  begin
                     nxt_inShift = {inShift_ff[5:0], dual_in_data1, serialIn};
                     nxt_bitCnt  = 5'h2;
                  end
               end
            ST_DATA:
            begin
               // shift out only on falling edges
               // write opcodes must not see the output counter
               if (fallEdge && (isRead || isDualRead))
               begin
                  nxt_outEn    = 1'b1;
                  nxt_outFirst = 1'b0;
                  if (outFirst_ff)
                     loadOut = 1'b1;
                  else
                     advOut = 1'b1;
                  nxt_bitCnt = bitCnt_ff + (isDualRead ? 5'h2 : 5'h1);
                  if (!outFirst_ff && bitCnt_ff + (isDualRead ? 5'h2 : 5'h1)
                      >= {1'b0, `SFS_BYTE_BITS})
                  begin
                     loadOut    = 1'b1;
                     advOut     = 1'b0;
                     nxt_bitCnt = 5'h00;
                  end
                  if (outFirst_ff)
                     nxt_bitCnt = 5'h00;
               end
               if (riseEdge && !isDualRead && !isRead)
               begin
                  // two bits per edge in dual program
                  if (isDualProg)
                     nxt_inShift = {inShift_ff[5:0], dual_in_data1, serialIn};
                  else
                     nxt_inShift = {inShift_ff[6:0], serialIn};
                  nxt_bitCnt = bitCnt_ff + (isDualProg ? 5'h2 : 5'h1);
                  if (byteDone)
                  begin
                     nxt_writeByte      = nxt_inShift;
                     nxt_writeByteValid = 1'b1;
                     nxt_bitCnt         = 5'h00;
                  end
               end
            end
            default:
               nxt_state = ST_IDLE;
         endcase
      end
   end

   // ========================================================================
   // standby deferral
   always @*
   begin
      nxt_pendStandby = pendStandby_ff;
      if (selected)
         nxt_pendStandby = 1'b0;
      else if (!selectN && engineBusy)
         nxt_pendStandby = 1'b1;
      else if (!engineBusy)
         nxt_pendStandby = 1'b0;
      else if (sclkPrev_ff && selectN && state_ff != ST_IDLE)
         nxt_pendStandby = 1'b1;
   end

   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         state_ff          <= ST_IDLE;
         sclkPrev_ff       <= 1'b0;
         holdActive_ff     <= 1'b0;
         bitCnt_ff         <= 5'h00;
         inShift_ff        <= `SFS_BYTE_ZERO;
         address_ff        <= `SFS_ADDR_ZERO;
         opcode_ff         <= `SFS_BYTE_ZERO;
         opcodeValid_ff    <= 1'b0;
         addressValid_ff   <= 1'b0;
         writeByte_ff      <= `SFS_BYTE_ZERO;
         writeByteValid_ff <= 1'b0;
         outEn_ff          <= 1'b0;
         outFirst_ff       <= 1'b0;
         opEnd_ff          <= 1'b0;
         pendStandby_ff    <= 1'b0;
         hwLocked_ff       <= 1'b0;
      end
      else
      begin
         state_ff          <= nxt_state;
         sclkPrev_ff       <= serialClk;
         holdActive_ff     <= nxt_holdActive;
         bitCnt_ff         <= nxt_bitCnt;
         inShift_ff        <= nxt_inShift;
         address_ff        <= nxt_address;
         opcode_ff         <= nxt_opcode;
         opcodeValid_ff    <= nxt_opcodeValid;
         addressValid_ff   <= nxt_addressValid;
         writeByte_ff      <= nxt_writeByte;
         writeByteValid_ff <= nxt_writeByteValid;
         outEn_ff          <= nxt_outEn;
         outFirst_ff       <= nxt_outFirst;
         opEnd_ff          <= selectN && state_ff != ST_IDLE;
         pendStandby_ff    <= (selectN && state_ff != ST_IDLE && engineBusy) |
                              (nxt_pendStandby & engineBusy & selectN);
         hwLocked_ff       <= ~writeProtectN;
      end
   end

   sfs_shift_out u_shift_out
   (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .load     (loadOut),
      .loadByte (readByte),
      .advance  (advOut),
      .dualMode (isDualRead),
      .bitHi    (bitHi),
      .bitLo    (bitLo)
   );

   assign readByteReq = loadOut;
   assign standby     = selectN & ~pendStandby_ff & ~engineBusy;

   // ========================================================================
   // pin drivers
   // hold or deselect floats outputs
   assign serialOutOe = outEn_ff & selected & ~holdActive_ff & ~isDualProg;
   assign serialOut   = bitHi;
   // dual read turns input pin around
   assign serialInOe  = outEn_ff & selected & ~holdActive_ff & isDualRead;
   assign serialInOut = bitLo;

endmodule // sfs_spi_front_end

// ---- testbench/sfs_fe_assertions.sv ----
/*
 * port checker for the serial flash front end.
 * assumes a bind onto sfs_spi_front_end and a serial clock half period of 3+ cycles.
 */
`timescale 1ns/100ps

module sfs_fe_checker
(
   input wire       clk_sys,
   input wire       rst_n,
   input wire       selectN,
   input wire       serialClk,
   input wire       holdN,
   input wire       writeProtectN,
   input wire       engineBusy,
   input wire       serialOut,
   input wire       serialOutOe,
   input wire       serialInOe,
   input wire [7:0] opcode_ff,
   input wire       opcodeValid_ff,
   input wire       hwLocked_ff,
   input wire       standby
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // ========================================================================
   // pin and flag checks
   a_desel_float:
      assert property (selectN[*3] |-> !serialOutOe && !serialInOe)
      else $error("output enabled while deselected");
   a_standby_busy:
      assert property (engineBusy[*2] |-> !standby)
      else $error("standby while self timed cycle runs");
   a_standby_idle:
      assert property ((selectN && !engineBusy)[*4] |-> standby)
      else $error("no standby while deselected and idle");
   a_out_on_fall:
      assert property (serialOutOe && $past(serialOutOe) && serialOut != $past(serialOut)
                       |-> !$past(serialClk))
      else $error("output changed away from a falling edge");
   a_hold_float:
      assert property ((!holdN && !selectN)[*3] |-> !serialOutOe)
      else $error("output driven during hold");
   a_dual_read_oe:
      assert property (serialInOe |-> opcode_ff == 8'h3b)
      else $error("input pin driven outside dual read");
   a_wp_lock_set:
      assert property (!writeProtectN[*3] |-> hwLocked_ff)
      else $error("lock missing with write protect low");
   a_wp_lock_clr:
      assert property (writeProtectN[*3] |-> !hwLocked_ff)
      else $error("lock set with write protect high");
   a_opcode_pulse:
      assert property (opcodeValid_ff |=> !opcodeValid_ff)
      else $error("opcode strobe longer than one cycle");
endmodule // sfs_fe_checker

bind sfs_spi_front_end sfs_fe_checker u_chk
(
   .clk_sys        (clk_sys),
   .rst_n          (rst_n),
   .selectN        (selectN),
   .serialClk      (serialClk),
   .holdN          (holdN),
   .writeProtectN  (writeProtectN),
   .engineBusy     (engineBusy),
   .serialOut      (serialOut),
   .serialOutOe    (serialOutOe),
   .serialInOe     (serialInOe),
   .opcode_ff      (opcode_ff),
   .opcodeValid_ff (opcodeValid_ff),
   .hwLocked_ff    (hwLocked_ff),
   .standby        (standby)
);

// ---- testbench/sfs_host_model.sv ----
/*
 * serial host model: select, serial clock, both data lanes and hold.
 * assumes siPin and soPin are the resolved pin levels; moves on falling clk_sys.
 */
`timescale 1ns/100ps

module sfs_host_model
(
   input  wire clk_sys,
   input  wire siPin,
   input  wire soPin,
   output reg  selectN,
   output reg  serialClk,
   output reg  hostSi,
   output reg  hostSo,
   output reg  holdN
);
   initial
   begin
      selectN = 1'b1;
      serialClk = 1'b0;
      hostSi = 1'b0;
      hostSo = 1'b1;
      holdN = 1'b1;
   end

   task automatic wt(input integer n);
      repeat (n) @(negedge clk_sys);
   endtask

   // data set with clock low, both lanes taken at rising edge
   task automatic bit2(input [1:0] d, output [1:0] q);
   begin
      serialClk = 1'b0;
      hostSi = d[0];
      hostSo = d[1];
      wt(3);
      serialClk = 1'b1;
      q = {soPin, siPin};
      wt(3);
   end
   endtask

   task automatic xfer(input [31:0] v, input integer n, input dl, output [31:0] r);
      integer   i;
      reg [1:0] q;
   begin
      r = 32'h0;
      for (i = n - 1; i >= 0; i = i - 1 - dl)
      begin
         bit2(dl ? {v[i], v[i - 1]} : {v[i], v[i]}, q);
         r = dl ? {r[29:0], q} : {r[30:0], q[1]};
      end
   end
   endtask

   // framing, clock idles at mode level
   task automatic start(input m3);
   begin
      serialClk = m3;
      wt(2);
      selectN = 1'b0;
      wt(3);
   end
   endtask

   task automatic stop(input m3);
   begin
      serialClk = m3;
      wt(3);
      selectN = 1'b1;
      hostSi = ~hostSi;
      hostSo = ~hostSo;
      wt(4);
   end
   endtask

   // hold only while selected with clock low
   task automatic pause;
      reg [1:0] q;
   begin
      serialClk = 1'b0;
      wt(3);
      holdN = 1'b0;
      bit2(2'b01, q);
      bit2(2'b10, q);
      serialClk = 1'b0;
      wt(3);
      holdN = 1'b1;
      wt(3);
   end
   endtask
endmodule // sfs_host_model

// ---- testbench/testbench.sv ----
/*
 * self checking bench for the serial flash front end.
 * assumes the host model drives the serial side; bench plays array and engine.
 */
`timescale 1ns/100ps
`include "sfs_consts.vh"
`define CHK(nm, ex, gt) begin checksDone = checksDone + 1; if ((gt) !== (ex)) begin \
   mismatches = mismatches + 1; $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end

module testbench;
   reg         clk_sys;
   reg         rst_n;
   reg         writeProtectN;
   reg         engineBusy;
   reg  [7:0]  readByte;
   wire        selectN, serialClk, hostSi, hostSo, holdN;
   wire        serialInOut, serialInOe, serialOut, serialOutOe, standby, hwLocked_ff;
   wire [7:0]  opcode_ff, writeByte_ff;
   wire [23:0] address_ff;
   wire        siPin = serialInOe ? serialInOut : hostSi;
   wire        soPin = serialOutOe ? serialOut : hostSo;
   integer     seed, mismatches, checksDone, k;
   reg  [31:0] r1, r2, rnd;
   reg  [23:0] adr;
   reg  [7:0]  wd, seen;
   wire        readByteReq, addressValid_ff, writeByteValid_ff, opEnd_ff;
   reg  [15:0] nReq, nAddr, nWr, nEnd;
   reg  [15:0] b0, b1, b2, b3;

   // pulse counters for the strobe outputs other than opcodeValid_ff
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         nReq  <= 16'h0000;
         nAddr <= 16'h0000;
         nWr   <= 16'h0000;
         nEnd  <= 16'h0000;
      end
      else
      begin
         nReq  <= nReq + readByteReq;
         nAddr <= nAddr + addressValid_ff;
         nWr   <= nWr + writeByteValid_ff;
         nEnd  <= nEnd + opEnd_ff;
      end
   end

   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   sfs_host_model h (.clk_sys(clk_sys), .siPin(siPin), .soPin(soPin), .selectN(selectN),
      .serialClk(serialClk), .hostSi(hostSi), .hostSo(hostSo), .holdN(holdN));

   sfs_spi_front_end dut (.clk_sys(clk_sys), .rst_n(rst_n), .selectN(selectN),
      .serialClk(serialClk), .serialIn(siPin), .serialInOut(serialInOut),
      .serialInOe(serialInOe), .dual_in_data1(soPin), .serialOut(serialOut),
      .serialOutOe(serialOutOe), .writeProtectN(writeProtectN), .holdN(holdN),
      .engineBusy(engineBusy), .readByte(readByte), .readByteReq(readByteReq),
      .opcode_ff(opcode_ff), .opcodeValid_ff(), .address_ff(address_ff),
      .addressValid_ff(addressValid_ff), .writeByte_ff(writeByte_ff),
      .writeByteValid_ff(writeByteValid_ff), .opEnd_ff(opEnd_ff),
      .hwLocked_ff(hwLocked_ff), .standby(standby));

   function [7:0] expData(input [7:0] op, input [7:0] rb, input [7:0] w);
      expData = (op == `SFS_OP_DUAL_PROG) ? w : rb;
   endfunction

   // one byte written per dual program frame
   function [15:0] expWr(input [7:0] op);
      expWr = (op == `SFS_OP_DUAL_PROG) ? 16'h0001 : 16'h0000;
   endfunction

   // first fall loads, the fall at mode 0 stop (ninth in single read, fifth in dual read) loads the next byte
   function [15:0] expReq(input [7:0] op, input m3);
      expReq = (op == `SFS_OP_DUAL_PROG) ? 16'h0000 : (m3 ? 16'h0001 : 16'h0002);
   endfunction

   task endOfTest;
   begin
      $display("checks %0d mismatches %0d", checksDone, mismatches);
      if (mismatches == 0 && checksDone > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
   endtask

   // one frame with a hold in the middle of the data
   task automatic run(input [7:0] op, input m3);
      reg dl;
   begin
      dl = (op != `SFS_OP_READ);
      rnd = $random(seed);
      adr = rnd[23:0];
      wd = rnd[31:24];
      rnd = $random(seed);
      readByte = rnd[7:0];
      b0 = nReq;
      b1 = nAddr;
      b2 = nWr;
      b3 = nEnd;
      h.start(m3);
      h.xfer({24'h0, op}, 8, 1'b0, r1);
      h.xfer({8'h0, adr}, 24, 1'b0, r1);
      if (op == `SFS_OP_DUAL_READ)
         h.xfer(32'h0, 8, 1'b0, r1);
      h.xfer({28'h0, wd[7:4]}, 4, dl, r1);
      h.pause;
      h.xfer({28'h0, wd[3:0]}, 4, dl, r2);
      h.stop(m3);
      seen = (op == `SFS_OP_DUAL_PROG) ? writeByte_ff : {r1[3:0], r2[3:0]};
      `CHK("opcode", op, opcode_ff)
      `CHK("address", adr, address_ff)
      `CHK("data", expData(op, readByte, wd), seen)
      `CHK("addressValid", 16'h0001, nAddr - b1)
      `CHK("writeValid", expWr(op), nWr - b2)
      `CHK("readRequests", expReq(op, m3), nReq - b0)
      `CHK("opEnd", 16'h0001, nEnd - b3)
   end
   endtask

   initial
   begin
      repeat (60000) @(posedge clk_sys);
      mismatches = mismatches + 1;
      endOfTest;
   end

   initial
   begin
      seed = 37;
      mismatches = 0;
      checksDone = 0;
      rst_n = 1'b0;
      writeProtectN = 1'b1;
      engineBusy = 1'b0;
      readByte = 8'h00;
      repeat (2) @(negedge clk_sys);
      rst_n = 1'b1;
      @(negedge clk_sys);
      `CHK("standby", 1'b1, standby)
      `CHK("outEnable", 1'b0, serialOutOe)
      for (k = 0; k < 6; k = k + 1)
         run((k % 3 == 0) ? `SFS_OP_READ : (k % 3 == 1) ? `SFS_OP_DUAL_READ
             : `SFS_OP_DUAL_PROG, k[0]);
      engineBusy = 1'b1;
      run(`SFS_OP_DUAL_PROG, 1'b0);
      `CHK("standbyBusy", 1'b0, standby)
      engineBusy = 1'b0;
      repeat (4) @(negedge clk_sys);
      `CHK("standbyIdle", 1'b1, standby)
      writeProtectN = 1'b0;
      repeat (4) @(negedge clk_sys);
      `CHK("locked", 1'b1, hwLocked_ff)
      writeProtectN = 1'b1;
      repeat (4) @(negedge clk_sys);
      `CHK("unlocked", 1'b0, hwLocked_ff)
      endOfTest;
   end
endmodule // testbench
